// ---- dv/hrpwm_checker.sv ----
// hrpwm_checker.sv: port-level assertions of the pulse width channel
// assumes settings hold within a frame and sample1 fits in one sub-frame
`include "hrpwm_defs.svh"

module hrpwm_checker import hrpwm_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire hrpwm_pkg::hrpwm_cfg_t cfg,
    input wire logic [`HRPWM_DUTY_W-1:0] filter_duty,
    input wire logic filter_valid,
    input wire logic align_in,
    input wire hrpwm_pkg::hrpwm_out_t pwm_out
);
    // ----------------------------------------------------------------
    // tallies between interrupt pulses
    // ----------------------------------------------------------------
    localparam int DIVT [16] = '{0, 0, 1, 3, 7, 15, 31, 47, 63, 79, 95, 127, 159, 191, 223, 255};
    logic [31:0] gap_reg;
    logic [15:0] t1_reg, t2_reg, al_reg;
    logic clean_reg;
    int fr;
    assign fr = DIVT[cfg.irq_div_sel] + 1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // a settings change or alignment spoils the running tally, so it is skipped
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {gap_reg, t1_reg, t2_reg, al_reg, clean_reg} <= '0;
        end else begin
            gap_reg <= pwm_out.period_irq ? 32'h1 : gap_reg + 32'h1;
            t1_reg <= (pwm_out.period_irq ? 16'h0 : t1_reg) + 16'(pwm_out.conv_trig1);
            t2_reg <= (pwm_out.period_irq ? 16'h0 : t2_reg) + 16'(pwm_out.conv_trig2);
            al_reg <= (pwm_out.period_irq ? 16'h0 : al_reg) + 16'(pwm_out.align_out);
            clean_reg <= (pwm_out.period_irq | clean_reg) & $stable(cfg) & !align_in;
        end
    end
    tick_spacing_a: assert property (
        pwm_out.ctl_tick |=> !pwm_out.ctl_tick [*3] ##1 pwm_out.ctl_tick) else $error("tick spacing");
    irq_pair_a: assert property (
        pwm_out.period_irq == pwm_out.gen_conv_trig) else $error("irq and converter trigger apart");
    irq_ratio_a: assert property (
        pwm_out.period_irq && clean_reg |-> gap_reg == fr * (cfg.period + 1))
        else $error("irq spacing");
    over_count_a: assert property (
        pwm_out.period_irq && clean_reg |-> t1_reg == fr << cfg.oversample)
        else $error("oversample trigger count");
    trig2_count_a: assert property (
        pwm_out.period_irq && clean_reg |-> t2_reg == fr) else $error("sample trigger count");
    align_count_a: assert property (
        pwm_out.period_irq && clean_reg && cfg.phase_trig <= cfg.period |-> al_reg == fr)
        else $error("alignment pulse count");
    align_pulse_a: assert property (
        pwm_out.align_out |=> !pwm_out.align_out) else $error("alignment pulse too long");
    rise_step_b_a: assert property (
        $rose(pwm_out.out_b ^ cfg.pol_b_low) && $stable(cfg)
        && cfg.pol_b_low == $past(cfg.pol_b_low, 2)
        |-> pwm_out.step_b == cfg.event3[3:0]) else $error("rise step b");
    fall_step_b_a: assert property (
        $fell(pwm_out.out_b ^ cfg.pol_b_low) && $stable(cfg)
        && cfg.pol_b_low == $past(cfg.pol_b_low, 2)
        |-> pwm_out.step_b == 4'(cfg.event4[3:0] + cfg.trim_b[3:0])) else $error("fall step b");
    fall_step_a: assert property (
        $fell(pwm_out.out_a ^ cfg.pol_a_low) && $stable(cfg) && cfg.open_loop
        && cfg.pol_a_low == $past(cfg.pol_a_low, 2)
        |-> pwm_out.step_a == 4'(cfg.event2[3:0] + cfg.trim_a[3:0])) else $error("fall step");
endmodule // hrpwm_checker

bind hrpwm_channel hrpwm_checker chk_i (.mclk(mclk), .nrst(nrst), .cfg(cfg),
    .filter_duty(filter_duty), .filter_valid(filter_valid), .align_in(align_in),
    .pwm_out(pwm_out));

// ---- dv/hrpwm_peer.sv ----
// hrpwm_peer.sv: peer channel driving the alignment line of the channel
// assumes fire is driven just after the rising edge of mclk
module hrpwm_peer (
    input wire logic mclk,
    input wire logic fire,
    output logic align
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // alignment source
    // ----------------------------------------------------------------
    logic fire_reg = 1'b0;
    // registered, so the line moves an edge after the request like a real peer
    always_ff @(posedge mclk) begin
        fire_reg <= fire;
    end
    assign align = fire_reg;
endmodule // hrpwm_peer

// ---- dv/test_high_res_pwm_channel.sv ----
// test_high_res_pwm_channel.sv: self-checking bench of the pulse width channel
// assumes the bound checker and the peer model are compiled alongside
`include "hrpwm_defs.svh"

module test_high_res_pwm_channel import hrpwm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // rows, state and tasks
    // ----------------------------------------------------------------
    typedef struct {
        logic [13:0] p, e1;
        logic [1:0] os;
        logic [3:0] sel;
        logic [17:0] e2;
        logic pol;
        int g, n1, na;
    } hrpwm_row_t;
    hrpwm_row_t rows [5] = '{
        '{14'h0009, 14'h0001, 2'h0, 4'h1, 18'h00050, 1'b0, 10, 1, 4},
        '{14'h003F, 14'h0000, 2'h3, 4'h2, 18'h00205, 1'b1, 128, 16, 64},
        '{14'h001F, 14'h0002, 2'h1, 4'h7, 18'h000A0, 1'b0, 1536, 96, 384},
        '{14'h000F, 14'h0003, 2'h2, 4'h0, 18'h000C3, 1'b1, 16, 4, 9},
        '{14'h0007, 14'h0000, 2'h0, 4'hF, 18'h00040, 1'b0, 2048, 256, 1024}};
    logic mclk = 1'b0;
    logic nrst, dval, fire, align;
    logic [`HRPWM_DUTY_W-1:0] duty;
    hrpwm_cfg_t cfg, c;
    hrpwm_out_t pwm_out;
    int miscompares = 0;
    int compares = 0;
    int g, n1, n2, na, nb, nc, nd, fr;
    hrpwm_channel dut (.mclk(mclk), .nrst(nrst), .cfg(cfg), .filter_duty(duty),
        .filter_valid(dval), .align_in(align), .pwm_out(pwm_out));
    hrpwm_peer peer (.mclk(mclk), .fire(fire), .align(align));
    // 20 MHz clock
    always #25 mclk = ~mclk;
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // tallies all frames up to the next interrupt; skip first waits for a fresh one
    task automatic meas(input bit skip);
        int k;
        k = 0;
        {g, n1, n2, na, nb, nc, nd} = 224'h0;
        while (skip && k < 20000) begin
            @(negedge mclk);
            k++;
            skip = (pwm_out.period_irq !== 1'b1);
        end
        do begin
            @(negedge mclk);
            g++;
            n1 += pwm_out.conv_trig1;
            n2 += pwm_out.conv_trig2;
            na += pwm_out.out_a ^ c.pol_a_low;
            nb += pwm_out.blank_a;
            nc += pwm_out.out_b ^ c.pol_b_low;
            nd += pwm_out.blank_b;
        end while (pwm_out.period_irq !== 1'b1 && g < 20000);
    endtask
    task automatic complete_run();
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        c = '0;
        c.sample2 = 12'h001;
        c.phase_trig = 14'h0003;
        c.blank_a_begin = 14'h0002;
        c.blank_a_end = 14'h0006;
        c.blank_b_end = 14'h0005;
        c.event3 = 18'h00013;
        c.event4 = 18'h00067;
        c.open_loop = 1'b1;
        cfg = c;
        {nrst, dval, fire} = 3'h0;
        duty = 24'h100000;
        repeat (2) @(posedge mclk);
        chk(pwm_out === '0, "outputs active in reset");
        nrst <= 1'b1;
        dval <= 1'b1;
        foreach (rows[i]) begin
            c.period = rows[i].p;
            c.oversample = rows[i].os;
            c.irq_div_sel = rows[i].sel;
            c.event1 = rows[i].e1;
            c.event2 = rows[i].e2;
            c.pol_a_low = rows[i].pol;
            @(posedge mclk);
            cfg <= c;
            dval <= 1'b0;
            meas(1);
            meas(1);
            fr = rows[i].g / (rows[i].p + 1);
            chk(g == rows[i].g, "irq spacing");
            chk(n1 == rows[i].n1, "oversample triggers");
            chk(n2 == fr, "sample triggers");
            chk(na == rows[i].na, "output a width");
            chk(nb == 4 * fr, "blank width");
            chk(nc == 5 * fr, "output b width");
            chk(nd == 5 * fr, "blank b width");
        end
        // closed loop: half duty plus a trim of one cycle and two steps
        c.period = 14'h0013;
        c.irq_div_sel = 4'h1;
        c.oversample = 2'h0;
        c.event1 = 14'h0000;
        c.pol_a_low = 1'b0;
        c.open_loop = 1'b0;
        c.trim_a = 16'sh0012;
        @(posedge mclk);
        cfg <= c;
        duty <= 24'h400000;
        dval <= 1'b1;
        @(posedge mclk);
        dval <= 1'b0;
        meas(1);
        meas(1);
        chk(na == 10, "closed loop width");
        // the peer restarts the frame shortly after an interrupt
        meas(1);
        @(posedge mclk);
        fire <= 1'b1;
        meas(0);
        chk(g >= 25 && g <= 28, "alignment restart");
        @(posedge mclk);
        fire <= 1'b0;
        // a mid-frame period change waits for the frame end
        c.period = 14'h0009;
        c.open_loop = 1'b1;
        c.trim_a = 16'sh0000;
        c.event2 = 18'h00050;
        meas(1);
        @(posedge mclk);
        cfg <= c;
        meas(0);
        chk(g == 20, "period changed mid-frame");
        meas(0);
        chk(g == 10, "new period not taken");
        @(posedge mclk);
        nrst <= 1'b0;
        @(negedge mclk);
        chk(pwm_out === '0, "outputs active in second reset");
        @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        complete_run();
    end
    // watchdog at forty thousand cycles, over twice what the sequence needs
    initial begin
        #2000000;
        miscompares++;
        complete_run();
    end
endmodule // test_high_res_pwm_channel

// ---- verilog/hrpwm_channel.sv ----
// hrpwm_channel.sv: one pulse width channel with outputs a and b
// assumes mclk is the fast pulse clock; sub-cycle steps drive an external
// sixteen-phase selector; align_in is asynchronous and is synchronised here
`include "hrpwm_defs.svh"

module hrpwm_channel (
    input wire logic mclk,
    input wire logic nrst,
    input wire hrpwm_pkg::hrpwm_cfg_t cfg,
    input wire logic [`HRPWM_DUTY_W-1:0] filter_duty,
    input wire logic filter_valid,
    input wire logic align_in,
    output hrpwm_pkg::hrpwm_out_t pwm_out
);
    import hrpwm_pkg::*;

    // ---------------------------------------------------------------
    // operation notes
    // ---------------------------------------------------------------
    // frame: the counter runs 0..period_act, period+1 cycles a frame
    // period_act is a shadow copy of the period setting
    // it loads only at frame end or at an alignment restart
    // so a period written mid-frame never cuts the running frame
    // after reset the shadow holds the long default period
    // so the first frame after reset is long whatever is set
    // an alignment restart does not end a frame for the interrupt
    // so the frame cut by a restart raises no interrupt of its own
    //
    // compares: every event is tested against the registered counter
    // an output moves one edge after the count that matches it
    // this keeps every top output straight out of a flip-flop
    // the cost is one cycle of latency on every edge and pulse
    // an event beyond the active period never fires; the falls of event2 and event4 saturate to it
    //
    // edges: event1 holds whole cycles only, it has no step part
    // events two to four carry a cycle part and a step part
    // the step part leaves on step_a and step_b as a level
    // an outside sixteen-phase selector turns it into sub-cycle delay
    // step_a follows the falling edge of output a only
    // step_b follows both edges of output b
    // hazard: the selector must take step_b before the next b edge
    // trims act on the falling edges only, in step units, signed
    // a trimmed edge is saturated into 0..period, never wrapped
    // polarity is applied after the edge logic, per output
    //
    // closed loop: event2 comes from the latched filter duty
    // the duty is a q23 fraction scaled by the active period
    // negative duty gives no on-time; the top code gives a full frame
    // open loop: event2 comes from the setting, the filter is ignored
    // the duty register still follows the filter in open loop
    // so switching back to closed loop uses the latest duty at once
    //
    // alignment: align_in passes two flip-flops, then an edge detector
    // the detector reads only the second stage, never the first
    // a rising edge restarts the counter three edges after the pin
    // a level held high restarts the frame only once
    // align_out pulses one cycle when the counter meets phase_trig
    // a phase_trig beyond the period gives no alignment pulse
    //
    // sampling: sample counts are in control clock units
    // they are scaled by four here to match the fast counter
    // the low two bits of a fast count cannot be reached that way
    // trigger one repeats period/factor apart when oversampling
    // its sub counter restarts at each frame start and restart
    // a sample1 beyond one sub-frame never fires at all
    // trigger two fires once a frame and is never oversampled
    // blanking windows come straight from their settings in any mode
    // a window whose begin lies after its end wraps the frame end
    //
    // interrupt: counts whole frames, fires at a frame end
    // it fires once every count+1 frames of the divide table
    // a divide setting of zero behaves like setting one
    // the same pulse doubles as the general_converter trigger
    // lowering the divide below the frames already counted fires at the next frame end
    //
    // control clock: ctl_tick is a one-cycle enable every four cycles
    // it is free-running from reset and not tied to the frame
    // so it keeps a steady rate across period changes and restarts
    //
    // limitations: settings are used as levels, without synchronisers
    // they must come from logic on mclk, not straight from pins
    // a settings change mid-frame may give one odd frame
    // the shadow period is the only setting guarded against that
    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------

    // q23 fraction times period in step units; negatives clamp to zero
    function automatic logic [`HRPWM_EV_W-1:0] duty_to_edge(
        input logic [`HRPWM_DUTY_W-1:0] duty,
        input logic [`HRPWM_CNT_W-1:0] period
    );
        logic [`HRPWM_DUTY_W+`HRPWM_EV_W-1:0] prod;
        logic [`HRPWM_EV_W-1:0] full;
        full = {period, {`HRPWM_HR_W{1'b0}}};
        prod = {{`HRPWM_EV_W{1'b0}}, duty} * {{`HRPWM_DUTY_W{1'b0}}, full};
        if (duty[`HRPWM_DUTY_W-1] && duty[`HRPWM_DUTY_FRAC-1:0] == '0) begin
            duty_to_edge = full; // top code read as exactly 1.0
        end else if (duty[`HRPWM_DUTY_W-1]) begin
            duty_to_edge = '0;
        end else begin
            duty_to_edge = prod[`HRPWM_DUTY_FRAC +: `HRPWM_EV_W];
        end
    endfunction

    // falling edge plus signed trim, saturated into the period
    function automatic logic [`HRPWM_EV_W-1:0] add_trim(
        input logic [`HRPWM_EV_W-1:0] edge_pos,
        input logic signed [`HRPWM_ADJ_W-1:0] trim,
        input logic [`HRPWM_CNT_W-1:0] period
    );
        logic signed [`HRPWM_EV_W+1:0] sum;
        logic signed [`HRPWM_EV_W+1:0] lim;
        sum = $signed({2'b00, edge_pos}) + (`HRPWM_EV_W+2)'(trim);
        lim = $signed({2'b00, period, {`HRPWM_HR_W{1'b0}}});
        if (sum < 0) begin
            add_trim = '0;
        end else if (sum > lim) begin
            add_trim = lim[`HRPWM_EV_W-1:0];
        end else begin
            add_trim = sum[`HRPWM_EV_W-1:0];
        end
    endfunction

    // interrupt divide setting to count; setting 0 treated as 1
    function automatic logic [`HRPWM_IRQ_W-1:0] irq_count(input logic [3:0] sel);
        case (sel)
            4'h2: irq_count = 8'h01;
            4'h3: irq_count = 8'h03;
            4'h4: irq_count = 8'h07;
            4'h5: irq_count = 8'h0F;
            4'h6: irq_count = 8'h1F;
            4'h7: irq_count = 8'h2F;
            4'h8: irq_count = 8'h3F;
            4'h9: irq_count = 8'h4F;
            4'hA: irq_count = 8'h5F;
            4'hB: irq_count = 8'h7F;
            4'hC: irq_count = 8'h9F;
            4'hD: irq_count = 8'hBF;
            4'hE: irq_count = 8'hDF;
            4'hF: irq_count = 8'hFF;
            default: irq_count = 8'h00;
        endcase
    endfunction

    // window test: level high from begin up to but excluding end
    function automatic logic in_window(
        input logic [`HRPWM_CNT_W-1:0] c,
        input logic [`HRPWM_CNT_W-1:0] b,
        input logic [`HRPWM_CNT_W-1:0] e
    );
        if (b <= e) begin
            in_window = (c >= b) && (c < e);
        end else begin
            in_window = (c >= b) || (c < e); // window wraps the period end
        end
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    hrpwm_state_t state_reg;
    hrpwm_state_t state_next;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic align_edge;
        logic period_end;
        logic [`HRPWM_EV_W-1:0] fall_a;
        logic [`HRPWM_EV_W-1:0] fall_b;
        logic [`HRPWM_EV_W-1:0] e2;
        logic [`HRPWM_CNT_W-1:0] seg;
        logic [`HRPWM_CNT_W-1:0] smp1;
        logic [`HRPWM_CNT_W-1:0] smp2;
        logic [`HRPWM_CNT_W-1:0] cnt_n;
        logic raw_a_n;
        logic raw_b_n;
        align_edge = 1'b0;
        period_end = 1'b0;
        fall_a = '0;
        fall_b = '0;
        e2 = '0;
        seg = '0;
        smp1 = '0;
        smp2 = '0;
        cnt_n = '0;
        raw_a_n = 1'b0;
        raw_b_n = 1'b0;
        state_next = state_reg;

        // only the second synchroniser stage feeds the edge detector
        state_next.sync_ff = {state_reg.sync_ff[0], align_in};
        state_next.sync_prev = state_reg.sync_ff[1];
        align_edge = state_reg.sync_ff[1] && !state_reg.sync_prev;

        // quarter-rate control clock enable
        state_next.ctl_div = state_reg.ctl_div + 2'h1;
        state_next.o.ctl_tick = (state_reg.ctl_div == `HRPWM_CTL_DIV);

        // duty latched from the loop filter; unused in open loop
        if (filter_valid) begin
            state_next.duty = filter_duty;
        end

        // time base: wrap at active period, restart on alignment
        period_end = (state_reg.cnt >= state_reg.period_act);
        if (align_edge) begin
            cnt_n = '0;
        end else if (period_end) begin
            cnt_n = '0;
        end else begin
            cnt_n = state_reg.cnt + `HRPWM_CNT_W'(1);
        end
        state_next.cnt = cnt_n;
        if (period_end || align_edge) begin
            state_next.period_act = cfg.period;
        end

        // edge positions: event2 from filter unless open loop
        e2 = cfg.open_loop ? cfg.event2 : duty_to_edge(state_reg.duty, state_reg.period_act);
        fall_a = add_trim(e2, cfg.trim_a, state_reg.period_act);
        fall_b = add_trim(cfg.event4, cfg.trim_b, state_reg.period_act);

        // cycle compares; event1 has no sub-cycle part
        raw_a_n = state_reg.raw_a;
        if (state_reg.cnt == cfg.event1) begin
            raw_a_n = 1'b1;
        end
        if (state_reg.cnt == fall_a[`HRPWM_EV_W-1:`HRPWM_HR_W]) begin
            raw_a_n = 1'b0;
            state_next.o.step_a = fall_a[`HRPWM_HR_W-1:0];
        end
        raw_b_n = state_reg.raw_b;
        if (state_reg.cnt == cfg.event3[`HRPWM_EV_W-1:`HRPWM_HR_W]) begin
            raw_b_n = 1'b1;
            state_next.o.step_b = cfg.event3[`HRPWM_HR_W-1:0];
        end
        if (state_reg.cnt == fall_b[`HRPWM_EV_W-1:`HRPWM_HR_W]) begin
            raw_b_n = 1'b0;
            state_next.o.step_b = fall_b[`HRPWM_HR_W-1:0];
        end
        state_next.raw_a = raw_a_n;
        state_next.raw_b = raw_b_n;
        state_next.o.out_a = raw_a_n ^ cfg.pol_a_low;
        state_next.o.out_b = raw_b_n ^ cfg.pol_b_low;

        // alignment pulse out for a slaved channel
        state_next.o.align_out = (state_reg.cnt == cfg.phase_trig);

        // blanking windows straight from their settings
        state_next.o.blank_a = in_window(state_reg.cnt, cfg.blank_a_begin,
            cfg.blank_a_end);
        state_next.o.blank_b = in_window(state_reg.cnt, cfg.blank_b_begin,
            cfg.blank_b_end);

        // sample counts scaled from control clock units
        smp1 = {cfg.sample1, {`HRPWM_CTL_SHIFT{1'b0}}};
        smp2 = {cfg.sample2, {`HRPWM_CTL_SHIFT{1'b0}}};

        // oversampling: sub counter repeats every period/factor
        seg = state_reg.period_act >> cfg.oversample;
        if (align_edge || period_end || state_reg.sub_cnt >= seg) begin
            state_next.sub_cnt = '0;
        end else begin
            state_next.sub_cnt = state_reg.sub_cnt + `HRPWM_CNT_W'(1);
        end
        state_next.o.conv_trig1 = (state_reg.sub_cnt == smp1);
        state_next.o.conv_trig2 = (state_reg.cnt == smp2);

        // scaled per-period interrupt, also a general_converter trigger
        state_next.o.period_irq = 1'b0;
        state_next.o.gen_conv_trig = 1'b0;
        if (period_end) begin
            if (state_reg.irq_cnt >= irq_count(cfg.irq_div_sel)) begin
                state_next.irq_cnt = '0;
                state_next.o.period_irq = 1'b1;
                state_next.o.gen_conv_trig = 1'b1;
            end else begin
                state_next.irq_cnt = state_reg.irq_cnt + `HRPWM_IRQ_W'(1);
            end
        end
    end

    // ---------------------------------------------------------------
    // state register; period resets to a constant, not to the port
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
            state_reg.period_act <= `HRPWM_PERIOD_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pwm_out = state_reg.o;

endmodule // hrpwm_channel

// ---- verilog/hrpwm_defs.svh ----
// hrpwm_defs.svh: constants of the high resolution pulse width channel
// assumes inclusion by its bare name from the package and the top module
`ifndef HRPWM_DEFS_SVH
`define HRPWM_DEFS_SVH

`define HRPWM_CNT_W 14
`define HRPWM_HR_W 4
`define HRPWM_EV_W 18
`define HRPWM_DUTY_W 24
`define HRPWM_DUTY_FRAC 23
`define HRPWM_ADJ_W 16
`define HRPWM_SMP_W 12
`define HRPWM_CTL_DIV 2'h3
`define HRPWM_CTL_SHIFT 2
`define HRPWM_PERIOD_RST 14'h0FFF
`define HRPWM_IRQ_W 8

`endif

// ---- verilog/hrpwm_pkg.sv ----
// hrpwm_pkg.sv: carrier types of the pulse width channel
// assumes hrpwm_defs.svh is on the include path
`include "hrpwm_defs.svh"

package hrpwm_pkg;

    // ---------------------------------------------------------------
    // configuration carrier, one static word per setting
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [`HRPWM_CNT_W-1:0] period;
        logic [`HRPWM_CNT_W-1:0] event1;
        logic [`HRPWM_EV_W-1:0] event2;
        logic [`HRPWM_EV_W-1:0] event3;
        logic [`HRPWM_EV_W-1:0] event4;
        logic signed [`HRPWM_ADJ_W-1:0] trim_a;
        logic signed [`HRPWM_ADJ_W-1:0] trim_b;
        logic [`HRPWM_CNT_W-1:0] phase_trig;
        logic [`HRPWM_SMP_W-1:0] sample1;
        logic [`HRPWM_SMP_W-1:0] sample2;
        logic [`HRPWM_CNT_W-1:0] blank_a_begin;
        logic [`HRPWM_CNT_W-1:0] blank_a_end;
        logic [`HRPWM_CNT_W-1:0] blank_b_begin;
        logic [`HRPWM_CNT_W-1:0] blank_b_end;
        logic [1:0] oversample;
        logic [3:0] irq_div_sel;
        logic open_loop;
        logic pol_a_low;
        logic pol_b_low;
    } hrpwm_cfg_t;

    // ---------------------------------------------------------------
    // output carrier
    // ---------------------------------------------------------------
    typedef struct packed {
        logic out_a;
        logic out_b;
        logic [`HRPWM_HR_W-1:0] step_a;
        logic [`HRPWM_HR_W-1:0] step_b;
        logic align_out;
        logic blank_a;
        logic blank_b;
        logic conv_trig1;
        logic conv_trig2;
        logic period_irq;
        logic gen_conv_trig;
        logic ctl_tick;
    } hrpwm_out_t;

    // ---------------------------------------------------------------
    // whole state of the channel
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sync_ff;
        logic sync_prev;
        logic [1:0] ctl_div;
        logic [`HRPWM_CNT_W-1:0] cnt;
        logic [`HRPWM_CNT_W-1:0] sub_cnt;
        logic [`HRPWM_CNT_W-1:0] period_act;
        logic [`HRPWM_DUTY_W-1:0] duty;
        logic [`HRPWM_IRQ_W-1:0] irq_cnt;
        logic raw_a;
        logic raw_b;
        hrpwm_out_t o;
    } hrpwm_state_t;

endpackage : hrpwm_pkg
